// File: hw/ccrs_cfg.svh
// Offsets, field positions, reset values and timing counts of the codec control bank.
`ifndef CCRS_CFG_SVH
`define CCRS_CFG_SVH
`define CCRS_ADDR_NOP 5'h00
`define CCRS_ADDR_CTL1 5'h01
`define CCRS_ADDR_CTL2 5'h02
`define CCRS_ADDR_CTL3 5'h03
`define CCRS_ADDR_CTL4 5'h04
`define CCRS_BIT_RNW 13
`define CCRS_ADDR_HI 12
`define CCRS_ADDR_LO 8
`define CCRS_C1_SWRST 7
`define CCRS_C1_PWDN 6
`define CCRS_C1_ADC_AUX 5
`define CCRS_C1_MON_AUX 4
`define CCRS_C1_MGAIN_HI 3
`define CCRS_C1_MGAIN_LO 2
`define CCRS_C1_DLOOP 1
`define CCRS_C1_DAC16 0
`define CCRS_C2_OVF 5
`define CCRS_C2_ADC16 4
`define CCRS_C2_FSD_DIS 2
`define CCRS_C2_RD_MASK 8'hDF
`define CCRS_C3_DLY_HI 5
`define CCRS_C3_SLV_HI 7
`define CCRS_C3_SLV_LO 6
`define CCRS_C4_PLL_BYP 7
`define CCRS_C4_N_HI 6
`define CCRS_C4_N_LO 4
`define CCRS_REG_RESET 8'h00
`define CCRS_DLY_MIN 6'h12
`define CCRS_N_ZERO_VAL 4'h8
`endif

// File: hw/ccrs_pkg.sv
// Types shared by the codec control bank.
package ccrs_pkg;
    typedef struct packed {
        logic valid;
        logic [15:0] word;
    } ccrs_sec_s;
    typedef struct packed {
        logic valid;
        logic [15:0] word;
    } ccrs_rsp_s;
    typedef struct packed {
        logic soft_reset;
        logic power_down;
        logic adc_aux_sel;
        logic mon_aux_sel;
        logic [1:0] mon_gain;
        logic dig_loopback;
        logic dac_16bit;
        logic adc_16bit;
        logic fsd_enable;
        logic [5:0] fsd_delay;
        logic [1:0] slave_count;
        logic [1:0] in_gain;
        logic [1:0] out_gain;
        logic [3:0] rate_div_n;
        logic pll_bypass;
    } ccrs_ctl_s;
    typedef enum logic [1:0] {
        CCRS_IDLE = 2'b00,
        CCRS_RESET = 2'b01
    } ccrs_state_e;
endpackage

// File: hw/ccrs_regs.sv
// Control register bank written and read by secondary serial words.
`timescale 1ns/1ps
`include "ccrs_cfg.svh"
module ccrs_regs (
    input wire logic clk,
    input wire logic rst_n,
    input wire ccrs_pkg::ccrs_sec_s sec_in,
    input wire logic fir_overflow,
    input wire logic fsd_variant,
    output ccrs_pkg::ccrs_rsp_s sec_out,
    output ccrs_pkg::ccrs_ctl_s ctl,
    output logic delay_below_min
);
    logic [7:0] c1_q, c1_d, c2_q, c2_d, c3_q, c3_d, c4_q, c4_d;
    ccrs_pkg::ccrs_rsp_s rsp_q, rsp_d;
    ccrs_pkg::ccrs_state_e st_q, st_d;
    logic [4:0] addr;
    logic rnw;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic hit_ok;
    logic addr_ok;

    assign addr = sec_in.word[`CCRS_ADDR_HI:`CCRS_ADDR_LO];
    assign wdata = sec_in.word[7:0];
    assign rnw = sec_in.word[`CCRS_BIT_RNW];
    // Upper bits must be zero or the word is ignored like a no-op.
    assign hit_ok = sec_in.valid && (sec_in.word[15:14] == 2'b00);
    assign addr_ok = (addr >= `CCRS_ADDR_CTL1) && (addr <= `CCRS_ADDR_CTL4);

    always_comb begin
        case (addr)
            `CCRS_ADDR_CTL1: rdata = c1_q;
            // Overflow bit reads live state; the stored bit 5 is masked off.
            `CCRS_ADDR_CTL2: rdata = (c2_q & `CCRS_C2_RD_MASK)
                | ({7'h00, fir_overflow} << `CCRS_C2_OVF);
            `CCRS_ADDR_CTL3: rdata = c3_q;
            `CCRS_ADDR_CTL4: rdata = c4_q;
            default: rdata = 8'h00;
        endcase
    end

    always_comb begin
        c1_d = c1_q;
        c2_d = c2_q;
        c3_d = c3_q;
        c4_d = c4_q;
        st_d = ccrs_pkg::CCRS_IDLE;
        rsp_d.valid = 1'b0;
        rsp_d.word = rsp_q.word;
        // The reset bit lives one cycle, then clears itself.
        if (st_q == ccrs_pkg::CCRS_RESET) begin
            c1_d[`CCRS_C1_SWRST] = 1'b0;
        end
        if (hit_ok && !rnw) begin
            case (addr)
                `CCRS_ADDR_CTL1: begin
                    c1_d = wdata;
                    if (wdata[`CCRS_C1_SWRST]) begin
                        st_d = ccrs_pkg::CCRS_RESET;
                    end
                end
                `CCRS_ADDR_CTL2: c2_d = wdata;
                `CCRS_ADDR_CTL3: c3_d = wdata;
                `CCRS_ADDR_CTL4: c4_d = wdata;
                default: c1_d = c1_d;
            endcase
        end
        if (hit_ok && rnw && addr_ok) begin
            rsp_d.valid = 1'b1;
            rsp_d.word = {sec_in.word[15:8], rdata};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            c1_q <= `CCRS_REG_RESET;
            c2_q <= `CCRS_REG_RESET;
            c3_q <= `CCRS_REG_RESET;
            c4_q <= `CCRS_REG_RESET;
            st_q <= ccrs_pkg::CCRS_IDLE;
            rsp_q <= '0;
        end else begin
            c1_q <= c1_d;
            c2_q <= c2_d;
            c3_q <= c3_d;
            c4_q <= c4_d;
            st_q <= st_d;
            rsp_q <= rsp_d;
        end
    end

    assign sec_out = rsp_q;

    always_comb begin
        ctl.soft_reset = c1_q[`CCRS_C1_SWRST];
        ctl.power_down = c1_q[`CCRS_C1_PWDN];
        ctl.adc_aux_sel = c1_q[`CCRS_C1_ADC_AUX];
        ctl.mon_aux_sel = c1_q[`CCRS_C1_MON_AUX];
        ctl.mon_gain = c1_q[`CCRS_C1_MGAIN_HI:`CCRS_C1_MGAIN_LO];
        ctl.dig_loopback = c1_q[`CCRS_C1_DLOOP];
        ctl.dac_16bit = c1_q[`CCRS_C1_DAC16];
        ctl.adc_16bit = c2_q[`CCRS_C2_ADC16];
        // The other variant has no delayed marker at all.
        ctl.fsd_enable = fsd_variant && !c2_q[`CCRS_C2_FSD_DIS];
        ctl.fsd_delay = c3_q[`CCRS_C3_DLY_HI:0];
        ctl.slave_count = c3_q[`CCRS_C3_SLV_HI:`CCRS_C3_SLV_LO];
        ctl.in_gain = c4_q[3:2];
        ctl.out_gain = c4_q[1:0];
        ctl.pll_bypass = c4_q[`CCRS_C4_PLL_BYP];
        // Code zero stands for the largest divisor.
        ctl.rate_div_n = (c4_q[`CCRS_C4_N_HI:`CCRS_C4_N_LO] == 3'h0)
            ? `CCRS_N_ZERO_VAL : {1'b0, c4_q[`CCRS_C4_N_HI:`CCRS_C4_N_LO]};
    end

    // Flags a delay the host should never program; no correction applied.
    assign delay_below_min = (c3_q[5:0] < `CCRS_DLY_MIN);

    // Decoded strobes shared by the checks below; each names one access
    // kind so that a check reads as the rule it guards.
    logic wr_c1, wr_c2, wr_c3, wr_c4, rd_hit;
    assign wr_c1 = hit_ok && !rnw && (addr == `CCRS_ADDR_CTL1);
    assign wr_c2 = hit_ok && !rnw && (addr == `CCRS_ADDR_CTL2);
    assign wr_c3 = hit_ok && !rnw && (addr == `CCRS_ADDR_CTL3);
    assign wr_c4 = hit_ok && !rnw && (addr == `CCRS_ADDR_CTL4);
    assign rd_hit = hit_ok && rnw && addr_ok;

    // A reset request must show up on the very next cycle.
    a_swrst_sets: assert property (
        @(posedge clk) disable iff (!rst_n)
        wr_c1 && wdata[`CCRS_C1_SWRST]
        |=> ctl.soft_reset
    ) else $error("soft reset bit not set");

    // Only a fresh request may keep the reset bit up a second cycle.
    a_swrst_clears: assert property (
        @(posedge clk) disable iff (!rst_n)
        ctl.soft_reset
        |=> !ctl.soft_reset || $past(wr_c1 && wdata[`CCRS_C1_SWRST])
    ) else $error("soft reset bit did not self clear");

    a_swrst_state: assert property (
        @(posedge clk) disable iff (!rst_n)
        ctl.soft_reset
        |-> st_q == ccrs_pkg::CCRS_RESET
    ) else $error("clearing state missing");

    // The whole byte lands, the reset bit included, for one cycle.
    a_c1_lands: assert property (
        @(posedge clk) disable iff (!rst_n)
        wr_c1
        |=> c1_q == $past(wdata)
    ) else $error("control1 write lost");

    a_c2_lands: assert property (
        @(posedge clk) disable iff (!rst_n)
        wr_c2
        |=> c2_q == $past(wdata)
    ) else $error("control2 write lost");

    a_write_lands: assert property (
        @(posedge clk) disable iff (!rst_n)
        wr_c3
        |=> c3_q == $past(wdata)
    ) else $error("control3 write lost");

    a_c4_lands: assert property (
        @(posedge clk) disable iff (!rst_n)
        wr_c4
        |=> c4_q == $past(wdata)
    ) else $error("control4 write lost");

    // Without a write the stored bytes of control2 to control4 never drift.
    a_hold_quiet: assert property (
        @(posedge clk) disable iff (!rst_n)
        !(hit_ok && !rnw)
        |=> $stable(c2_q) && $stable(c3_q) && $stable(c4_q)
    ) else $error("register changed without a write");

    a_write_silent: assert property (
        @(posedge clk) disable iff (!rst_n)
        hit_ok && !rnw
        |=> !sec_out.valid
    ) else $error("write answered");

    // The answer carries the byte as it stood when the read was taken.
    a_read_answer: assert property (
        @(posedge clk) disable iff (!rst_n)
        rd_hit
        |=> sec_out.valid && sec_out.word[7:0] == $past(rdata)
    ) else $error("read answer wrong");

    a_read_echo: assert property (
        @(posedge clk) disable iff (!rst_n)
        rd_hit
        |=> sec_out.word[15:8] == $past(sec_in.word[15:8])
    ) else $error("read echo wrong");

    a_read_no_write: assert property (
        @(posedge clk) disable iff (!rst_n)
        hit_ok && rnw
        |=> $stable(c4_q) && $stable(c3_q) && $stable(c2_q)
    ) else $error("read changed a register");

    // An answer is a single-cycle pulse, never spontaneous.
    a_idle_quiet: assert property (
        @(posedge clk) disable iff (!rst_n)
        !sec_in.valid
        |=> !sec_out.valid
    ) else $error("answer without request");

    // Bit 7 may still be clearing from an earlier reset request.
    a_nop_ignored: assert property (
        @(posedge clk) disable iff (!rst_n)
        sec_in.valid && addr == `CCRS_ADDR_NOP
        |=> $stable(c1_q[6:0]) && $stable(c2_q) && $stable(c3_q)
    ) else $error("no-op changed a register");

    a_nop_silent: assert property (
        @(posedge clk) disable iff (!rst_n)
        sec_in.valid && addr == `CCRS_ADDR_NOP
        |=> !sec_out.valid && $stable(c4_q)
    ) else $error("no-op answered");

    // Unmapped places neither answer nor disturb the bank.
    a_high_addr: assert property (
        @(posedge clk) disable iff (!rst_n)
        sec_in.valid && addr > `CCRS_ADDR_CTL4
        |=> !sec_out.valid && $stable(c3_q) && $stable(c4_q)
    ) else $error("unmapped address acted");

    // A word with its top bits set is dropped as a whole.
    a_upper_bits: assert property (
        @(posedge clk) disable iff (!rst_n)
        sec_in.valid && sec_in.word[15:14] != 2'b00
        |=> !sec_out.valid
    ) else $error("bad word answered");

    a_upper_nowrite: assert property (
        @(posedge clk) disable iff (!rst_n)
        sec_in.valid && sec_in.word[15:14] != 2'b00
        |=> $stable(c2_q) && $stable(c3_q) && $stable(c4_q)
    ) else $error("bad word wrote a register");

    // The flag is sampled live in the cycle the read is taken.
    a_ovf_read: assert property (
        @(posedge clk) disable iff (!rst_n)
        rd_hit && addr == `CCRS_ADDR_CTL2
        |=> sec_out.word[5] == $past(fir_overflow)
    ) else $error("overflow flag not reported");

    // Code zero stands for the largest divisor.
    a_rate_code: assert property (
        @(posedge clk) disable iff (!rst_n)
        c4_q[6:4] == 3'h0
        |-> ctl.rate_div_n == 4'h8
    ) else $error("divisor code zero not eight");

    a_rate_plain: assert property (
        @(posedge clk) disable iff (!rst_n)
        c4_q[6:4] != 3'h0
        |-> ctl.rate_div_n == {1'b0, c4_q[6:4]}
    ) else $error("divisor code not passed through");

    // The variant without a delayed marker never enables it.
    a_fsd_gate: assert property (
        @(posedge clk) disable iff (!rst_n)
        !fsd_variant
        |-> !ctl.fsd_enable
    ) else $error("delayed marker on wrong variant");

    a_fsd_on: assert property (
        @(posedge clk) disable iff (!rst_n)
        fsd_variant && !c2_q[`CCRS_C2_FSD_DIS]
        |-> ctl.fsd_enable
    ) else $error("delayed marker not enabled");

    // Each field follows the byte written one cycle earlier.
    a_pwdn_write: assert property (
        @(posedge clk) disable iff (!rst_n)
        wr_c1
        |=> ctl.power_down == $past(wdata[6])
    ) else $error("power down field wrong");

    a_adc_select: assert property (
        @(posedge clk) disable iff (!rst_n)
        wr_c1
        |=> ctl.adc_aux_sel == $past(wdata[5])
    ) else $error("converter input select wrong");

    a_mon_select: assert property (
        @(posedge clk) disable iff (!rst_n)
        wr_c1
        |=> ctl.mon_aux_sel == $past(wdata[4])
    ) else $error("monitor input select wrong");

    a_mon_gain: assert property (
        @(posedge clk) disable iff (!rst_n)
        wr_c1
        |=> ctl.mon_gain == $past(wdata[3:2])
    ) else $error("monitor gain wrong");

    a_loopback_write: assert property (
        @(posedge clk) disable iff (!rst_n)
        wr_c1
        |=> ctl.dig_loopback == $past(wdata[1])
    ) else $error("loopback field wrong");

    a_dac_mode: assert property (
        @(posedge clk) disable iff (!rst_n)
        wr_c1
        |=> ctl.dac_16bit == $past(wdata[0])
    ) else $error("playback word mode wrong");

    // Capture word mode is kept apart from the playback mode.
    a_adc_mode: assert property (
        @(posedge clk) disable iff (!rst_n)
        wr_c2
        |=> ctl.adc_16bit == $past(wdata[4])
    ) else $error("capture word mode wrong");

    // A short delay is kept as written; only the flag reports it.
    a_fsd_delay: assert property (
        @(posedge clk) disable iff (!rst_n)
        wr_c3
        |=> ctl.fsd_delay == $past(wdata[5:0])
    ) else $error("marker delay wrong");

    a_slave_count: assert property (
        @(posedge clk) disable iff (!rst_n)
        wr_c3
        |=> ctl.slave_count == $past(wdata[7:6])
    ) else $error("slave count wrong");

    // Mute is a code of its own, so gains pass through unchanged.
    a_in_gain: assert property (
        @(posedge clk) disable iff (!rst_n)
        wr_c4
        |=> ctl.in_gain == $past(wdata[3:2])
    ) else $error("input gain wrong");

    a_out_gain: assert property (
        @(posedge clk) disable iff (!rst_n)
        wr_c4
        |=> ctl.out_gain == $past(wdata[1:0])
    ) else $error("output gain wrong");
endmodule

// File: sim/ccrs_host.sv
// Host serial port model that issues secondary words to the bank.
`timescale 1ns/1ps
module ccrs_host (
    input wire logic clk,
    input wire ccrs_pkg::ccrs_rsp_s sec_out,
    output ccrs_pkg::ccrs_sec_s sec_in
);
    initial sec_in = '0;
    task automatic xfer(input logic rnw, input logic [4:0] addr,
        input logic [7:0] data, output logic got, output logic [7:0] rd);
        logic [7:0] d;
        d = data;
        if (!rnw && addr == 5'h03 && d[5:0] < 6'd18) d[5:0] = 6'd18;
        if (!rnw && addr == 5'h02) d[1:0] = 2'b00;
        @(posedge clk);
        sec_in <= '{valid: 1'b1, word: {2'b00, rnw, addr, d}};
        @(posedge clk);
        // A released word never keeps its old value on the wire.
        sec_in <= '{valid: 1'b0, word: ~{2'b00, rnw, addr, d}};
        #1;
        got = sec_out.valid;
        rd = sec_out.word[7:0];
    endtask
    // Sends a raw word, top bits included, to probe refused words.
    task automatic raw(input logic [15:0] w, output logic got);
        @(posedge clk);
        sec_in <= '{valid: 1'b1, word: w};
        @(posedge clk);
        sec_in <= '{valid: 1'b0, word: ~w};
        #1;
        got = sec_out.valid;
    endtask
endmodule

// File: sim/tb_top.sv
// Self-checking bench for the codec control bank.
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic fir_overflow = 1'b0;
    logic fsd_variant = 1'b0;
    ccrs_pkg::ccrs_sec_s sec_in;
    ccrs_pkg::ccrs_rsp_s sec_out;
    ccrs_pkg::ccrs_ctl_s ctl;
    logic delay_below_min;
    int n_mismatch = 0;
    int tests_run = 0;
    logic [7:0] regs [1:4];
    logic got;
    logic [7:0] rd;
    logic [7:0] d;
    logic [7:0] exp;
    int a;
    always #25 clk = ~clk;
    ccrs_regs u_ccrs_regs (.clk(clk), .rst_n(rst_n), .sec_in(sec_in),
        .fir_overflow(fir_overflow), .fsd_variant(fsd_variant),
        .sec_out(sec_out), .ctl(ctl), .delay_below_min(delay_below_min));
    ccrs_host u_ccrs_host (.clk(clk), .sec_out(sec_out), .sec_in(sec_in));
    task automatic chk(input string what, input logic [31:0] e,
        input logic [31:0] s);
        tests_run++;
        if (s !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic check_ctl;
        logic [2:0] n;
        n = regs[4][6:4];
        chk("ctl_c1", 32'(regs[1]), 32'(ctl[26:19]));
        chk("ctl_rest", {13'h0000, regs[2][4], fsd_variant & ~regs[2][2],
            regs[3][5:0], regs[3][7:6], regs[4][3:0],
            (n == 3'h0) ? 4'h8 : {1'b0, n}, regs[4][7]},
            32'(ctl[18:0]));
        chk("below_min", 32'(regs[3][5:0] < 6'd18),
            32'(delay_below_min));
    endtask
    task automatic read_all;
        for (int r = 1; r <= 4; r++) begin
            @(posedge clk);
            fir_overflow <= 1'($urandom);
            #1;
            exp = (r == 2) ? {regs[2][7:6], fir_overflow, regs[2][4:0]}
                : regs[r];
            u_ccrs_host.xfer(1'b1, 5'(r), 8'h00, got, rd);
            chk("answer", 32'h1, 32'(got));
            chk("read", 32'(exp), 32'(rd));
        end
    endtask
    initial begin
        void'($urandom(32'h48f1));
        for (int pass = 0; pass < 2; pass++) begin
            @(posedge clk);
            rst_n <= 1'b0;
            fsd_variant <= pass[0];
            repeat (2) @(posedge clk);
            rst_n <= 1'b1;
            for (a = 1; a <= 4; a++) regs[a] = 8'h00;
            #1;
            check_ctl;
            read_all;
            repeat (24) begin
                a = $urandom_range(4, 1);
                d = 8'($urandom);
                if (a == 3 && d[5:0] < 6'd18) d[5:0] = 6'd18 + d[3:0];
                if (a == 2) d[1:0] = 2'b00;
                if (a == 1) d[7] = 1'b0;
                u_ccrs_host.xfer(1'b0, 5'(a), d, got, rd);
                regs[a] = d;
                check_ctl;
            end
            read_all;
            u_ccrs_host.xfer(1'b0, 5'h01, 8'h80 | regs[1], got, rd);
            chk("soft_reset on", 32'h1, 32'(ctl.soft_reset));
            @(posedge clk);
            #1;
            chk("soft_reset off", 32'h0, 32'(ctl.soft_reset));
            // Unmapped places must neither answer nor disturb the bank.
            foreach (regs[r]) begin
                a = (r == 1) ? 0 : (r == 2) ? 5 : (r == 3) ? 7 : 31;
                u_ccrs_host.xfer(1'b1, 5'(a), 8'h00, got, rd);
                chk("no answer", 32'h0, 32'(got));
                u_ccrs_host.xfer(1'b0, 5'(a), 8'hff, got, rd);
            end
            u_ccrs_host.raw(16'hE100, got);
            chk("bad word answer", 32'h0, 32'(got));
            u_ccrs_host.raw(16'h43FF, got);
            read_all;
        end
        test_done;
    end
endmodule
